// >>> hdl/bds_pkg.sv
// package: constants, types and state layout of the decimal-adjust / decrement-skip unit
package bds_pkg;

  // -------------------------------------------------------------------------
  // register map, byte offsets on the wishbone bus
  // -------------------------------------------------------------------------
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0C;
  localparam logic [7:0] OFS_MADDR = 8'h10;
  localparam logic [7:0] OFS_MDATA = 8'h14;
  localparam logic [7:0] OFS_INFO = 8'h18;

  // -------------------------------------------------------------------------
  // field positions and reset values
  // -------------------------------------------------------------------------
  localparam int INFO_BUSY_BIT = 0;
  localparam int INFO_SQUASH_BIT = 1;
  localparam int INFO_SQ2_BIT = 2;
  localparam int INFO_CYC_LSB = 16;
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_FLAGS = 5'h00;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [15:0] RST_CYCLES = 16'h0000;

  // -------------------------------------------------------------------------
  // opcodes and datapath constants
  // -------------------------------------------------------------------------
  localparam logic [15:0] OPC_DECIMAL_ADJUST = 16'h0007;
  localparam logic [5:0] PFX_DECREMENT_FILE = 6'h01;
  localparam logic [5:0] PFX_DEC_SKIP_ZERO = 6'h0B;
  localparam logic [5:0] PFX_DEC_SKIP_NONZERO = 6'h13;
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [3:0] BCD_CORRECTION = 4'h6;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  typedef enum logic [2:0] {
    PH_IDLE = 3'h0,
    PH_Q1 = 3'h1,
    PH_Q2 = 3'h3,
    PH_Q3 = 3'h2,
    PH_Q4 = 3'h6
  } bds_phase_t;

  typedef enum logic [2:0] {
    OP_NO_OPERATION = 3'h0,
    OP_DECIMAL_ADJUST = 3'h1,
    OP_DECREMENT_FILE = 3'h2,
    OP_DEC_SKIP_ZERO = 3'h3,
    OP_DEC_SKIP_NONZERO = 3'h4
  } bds_op_t;

  // bit order equals the status register layout, bit 4 down to bit 0
  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } bds_flags_t;

  typedef struct packed {
    bds_op_t op;
    logic dest_file;
    logic use_bank_select;
    logic [7:0] faddr;
  } bds_decoded_t;

  typedef struct packed {
    bds_phase_t phase;
    logic [15:0] opcode;
    bds_decoded_t dec;
    logic [7:0] acc;
    bds_flags_t flags;
    logic [3:0] bank;
    logic [11:0] maddr;
    logic [7:0] operand;
    logic [7:0] result;
    bds_flags_t res_flags;
    logic res_skip;
    logic squash_next;
    logic squash_second;
    logic ack;
    logic [31:0] rdata;
    logic [15:0] cycles;
  } bds_state_t;

endpackage

// >>> hdl/bds_unit.sv
// module: four-phase datapath for decimal adjust, decrement and decrement-skip
//
// Functional notes
// RULE1 - decimal adjust adds 6 to low nibble when above 9 or digit carry set
// RULE2 - decimal adjust adds 6 to high nibble when above 9 or carry set
// RULE3 - decimal adjust is opcode 0x0007, one cycle, touches only carry and digit carry
// RULE4 - decimal adjust turns a binary sum of packed BCD into packed BCD
// RULE5 - decrement opcode 0000 01da ffff ffff writes file value minus one
// RULE6 - destination bit 0 writes accumulator, 1 writes file register
// RULE7 - bank bit 0 uses access bank, 1 uses bank select register
// RULE8 - decrement updates carry, digit carry, negative, overflow, zero; one cycle
// RULE9 - 0010 11da decrements, skips next when result zero, flags untouched
// RULE10 - 0100 11da decrements, skips next when result nonzero, flags untouched
// RULE11 - skip replaces fetched word with no operation; two-word target costs two
// RULE12 - low correction carry enters high nibble first; high overflow sets carry
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps

module bds_unit #(
  parameter int BANKS = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic busy,
  output logic skip_pending
);

  // -------------------------------------------------------------------------
  // storage
  // -------------------------------------------------------------------------
  bds_pkg::bds_state_t s_q;
  bds_pkg::bds_state_t s_d;
  logic [7:0] file_mem [0:BANKS*256-1];
  logic mem_we;
  logic [11:0] mem_addr;
  logic [7:0] mem_wdata;

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  // words that carry a second instruction word behind them
  function automatic logic is_two_word(input logic [15:0] w);
    is_two_word = (w[15:12] == 4'hC) || (w[15:9] == 7'h76) || (w[15:8] == 8'hEE) ||
                  (w[15:8] == 8'hEF);
  endfunction

  function automatic logic [11:0] file_address(input logic use_bsr, input logic [7:0] f,
                                               input logic [3:0] bank_select_register);
    logic [3:0] bank;
    bank = bank_select_register;
    if (!use_bsr)
    begin
      bank = (f < bds_pkg::ACCESS_SPLIT) ? bds_pkg::ACCESS_LOW_BANK : bds_pkg::ACCESS_HIGH_BANK;
    end
    file_address = {bank, f};
  endfunction

  function automatic bds_pkg::bds_decoded_t decode(input logic [15:0] w);
    bds_pkg::bds_decoded_t dv;
    dv.op = bds_pkg::OP_NO_OPERATION;
    dv.dest_file = w[9];
    dv.use_bank_select = w[8];
    dv.faddr = w[7:0];
    if (w == bds_pkg::OPC_DECIMAL_ADJUST)
    begin
      dv.op = bds_pkg::OP_DECIMAL_ADJUST; // RULE3
    end
    else if (w[15:10] == bds_pkg::PFX_DECREMENT_FILE)
    begin
      dv.op = bds_pkg::OP_DECREMENT_FILE; // RULE5
    end
    else if (w[15:10] == bds_pkg::PFX_DEC_SKIP_ZERO)
    begin
      dv.op = bds_pkg::OP_DEC_SKIP_ZERO; // RULE9
    end
    else if (w[15:10] == bds_pkg::PFX_DEC_SKIP_NONZERO)
    begin
      dv.op = bds_pkg::OP_DEC_SKIP_NONZERO; // RULE10
    end
    decode = dv;
  endfunction

  // -------------------------------------------------------------------------
  // datapath combinational terms
  // -------------------------------------------------------------------------
  logic [4:0] low_sum;
  logic [4:0] high_in;
  logic [4:0] high_sum;
  logic low_fix;
  logic high_fix;
  logic [8:0] dec_sum;
  logic [4:0] dec_low;
  logic [7:0] daw_value;
  logic daw_carry;

  always_comb
  begin
    low_fix = (s_q.acc[3:0] > bds_pkg::BCD_MAX_DIGIT) || s_q.flags.digit_carry_flag; // RULE1
    low_sum = {1'b0, s_q.acc[3:0]} + (low_fix ? {1'b0, bds_pkg::BCD_CORRECTION} : 5'h00);
    // low carry folds into the high digit before it is tested
    high_in = {1'b0, s_q.acc[7:4]} + {4'h0, low_sum[4]}; // RULE12
    high_fix = (high_in > {1'b0, bds_pkg::BCD_MAX_DIGIT}) || s_q.flags.carry || high_in[4]; // RULE2
    high_sum = high_in + (high_fix ? {1'b0, bds_pkg::BCD_CORRECTION} : 5'h00);
    daw_value = {high_sum[3:0], low_sum[3:0]}; // RULE4
    // a carry already set stays set: the sum was past 99 before adjusting
    daw_carry = high_sum[4] || high_in[4] || s_q.flags.carry; // RULE12
    // decrement done as operand plus 0xFF, so carry reads as "no borrow"
    dec_sum = {1'b0, s_q.operand} + 9'h0FF; // RULE5
    dec_low = {1'b0, s_q.operand[3:0]} + 5'h0F;
  end

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  logic bus_req;
  logic bus_take;
  logic write_ok;

  always_comb
  begin
    s_d = s_q;
    bus_req = wb_cyc_i && wb_stb_i;
    // writes wait for an idle datapath so file and accumulator never race
    write_ok = !wb_we_i || (s_q.phase == bds_pkg::PH_IDLE);
    bus_take = s_q.ack && bus_req && wb_we_i && wb_sel_i[0];
    s_d.ack = bus_req && !s_q.ack && write_ok;
    mem_we = 1'b0;
    mem_addr = s_q.maddr;
    mem_wdata = wb_dat_i[7:0];

    if (bus_req && !s_q.ack && write_ok && !wb_we_i)
    begin
      s_d.rdata = 32'h0000_0000;
      unique case (wb_adr_i)
        bds_pkg::OFS_INSTR: s_d.rdata = {16'h0000, s_q.opcode};
        bds_pkg::OFS_ACC: s_d.rdata = {24'h00_0000, s_q.acc};
        bds_pkg::OFS_STATUS: s_d.rdata = {27'h000_0000, s_q.flags};
        bds_pkg::OFS_BANK: s_d.rdata = {28'h000_0000, s_q.bank};
        bds_pkg::OFS_MADDR: s_d.rdata = {20'h0_0000, s_q.maddr};
        bds_pkg::OFS_MDATA: s_d.rdata = {24'h00_0000, file_mem[s_q.maddr]};
        bds_pkg::OFS_INFO:
        begin
          s_d.rdata[bds_pkg::INFO_CYC_LSB +: 16] = s_q.cycles;
          s_d.rdata[bds_pkg::INFO_BUSY_BIT] = s_q.phase != bds_pkg::PH_IDLE;
          s_d.rdata[bds_pkg::INFO_SQUASH_BIT] = s_q.squash_next;
          s_d.rdata[bds_pkg::INFO_SQ2_BIT] = s_q.squash_second;
        end
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // bus writes act at the edge where the master samples ack
    if (bus_take)
    begin
      unique case (wb_adr_i)
        bds_pkg::OFS_INSTR:
        begin
          if (wb_sel_i[1])
          begin
            s_d.opcode = wb_dat_i[15:0];
            s_d.phase = bds_pkg::PH_Q1;
          end
        end
        bds_pkg::OFS_ACC: s_d.acc = wb_dat_i[7:0];
        bds_pkg::OFS_STATUS: s_d.flags = wb_dat_i[4:0];
        bds_pkg::OFS_BANK: s_d.bank = wb_dat_i[3:0];
        bds_pkg::OFS_MADDR:
        begin
          if (wb_sel_i[1])
          begin
            s_d.maddr = wb_dat_i[11:0];
          end
        end
        bds_pkg::OFS_MDATA: mem_we = 1'b1;
        default: mem_we = 1'b0;
      endcase
    end

    unique case (s_q.phase)
      bds_pkg::PH_IDLE: s_d.phase = s_d.phase;
      bds_pkg::PH_Q1:
      begin
        s_d.dec = decode(s_q.opcode);
        if (s_q.squash_next)
        begin
          // discarded word; a two-word one drags its second word along
          s_d.dec.op = bds_pkg::OP_NO_OPERATION; // RULE11
          s_d.squash_next = 1'b0;
          s_d.squash_second = is_two_word(s_q.opcode); // RULE11
        end
        else if (s_q.squash_second)
        begin
          s_d.dec.op = bds_pkg::OP_NO_OPERATION; // RULE11
          s_d.squash_second = 1'b0;
        end
        s_d.phase = bds_pkg::PH_Q2;
      end
      bds_pkg::PH_Q2:
      begin
        s_d.operand = file_mem[file_address(s_q.dec.use_bank_select, s_q.dec.faddr,
                                            s_q.bank)]; // RULE7
        if (s_q.dec.op == bds_pkg::OP_DECIMAL_ADJUST)
        begin
          s_d.operand = s_q.acc;
        end
        s_d.phase = bds_pkg::PH_Q3;
      end
      bds_pkg::PH_Q3:
      begin
        s_d.result = dec_sum[7:0];
        s_d.res_flags = s_q.flags;
        s_d.res_skip = 1'b0;
        unique case (s_q.dec.op)
          bds_pkg::OP_DECIMAL_ADJUST:
          begin
            s_d.result = daw_value;
            s_d.res_flags.carry = daw_carry; // RULE3
            s_d.res_flags.digit_carry_flag = low_sum[4]; // RULE3
          end
          bds_pkg::OP_DECREMENT_FILE:
          begin
            s_d.res_flags.carry = dec_sum[8]; // RULE8
            s_d.res_flags.digit_carry_flag = dec_low[4]; // RULE8
            s_d.res_flags.negative = dec_sum[7]; // RULE8
            s_d.res_flags.overflow_flag = s_q.operand[7] && !dec_sum[7]; // RULE8
            s_d.res_flags.zero = dec_sum[7:0] == 8'h00; // RULE8
          end
          bds_pkg::OP_DEC_SKIP_ZERO: s_d.res_skip = dec_sum[7:0] == 8'h00; // RULE9
          bds_pkg::OP_DEC_SKIP_NONZERO: s_d.res_skip = dec_sum[7:0] != 8'h00; // RULE10
          default: s_d.res_skip = 1'b0;
        endcase
        s_d.phase = bds_pkg::PH_Q4;
      end
      bds_pkg::PH_Q4:
      begin
        unique case (s_q.dec.op)
          bds_pkg::OP_DECIMAL_ADJUST:
          begin
            s_d.acc = s_q.result;
            s_d.flags = s_q.res_flags;
          end
          bds_pkg::OP_DECREMENT_FILE, bds_pkg::OP_DEC_SKIP_ZERO,
          bds_pkg::OP_DEC_SKIP_NONZERO:
          begin
            s_d.flags = s_q.res_flags; // RULE9
            if (s_q.dec.dest_file)
            begin
              mem_we = 1'b1; // RULE6
              mem_addr = file_address(s_q.dec.use_bank_select, s_q.dec.faddr, s_q.bank);
              mem_wdata = s_q.result;
            end
            else
            begin
              s_d.acc = s_q.result; // RULE6
            end
          end
          default: s_d.flags = s_q.flags;
        endcase
        if (s_q.res_skip)
        begin
          s_d.squash_next = 1'b1; // RULE11
        end
        s_d.res_skip = 1'b0;
        s_d.cycles = s_q.cycles + 16'h0001;
        s_d.phase = bds_pkg::PH_IDLE;
      end
      default: s_d.phase = bds_pkg::PH_IDLE;
    endcase
  end

  // -------------------------------------------------------------------------
  // registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q <= '0;
      s_q.phase <= bds_pkg::PH_IDLE;
      s_q.acc <= bds_pkg::RST_ACC;
      s_q.flags <= bds_pkg::RST_FLAGS;
      s_q.bank <= bds_pkg::RST_BANK;
      s_q.cycles <= bds_pkg::RST_CYCLES;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // file memory has no reset; software loads it before use
  always_ff @(posedge clk)
  begin
    if (mem_we)
    begin
      file_mem[mem_addr] <= mem_wdata;
    end
  end

  // -------------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------------
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdata;
  assign busy = s_q.phase != bds_pkg::PH_IDLE;
  assign skip_pending = s_q.squash_next || s_q.squash_second;

endmodule

// >>> tb/bds_checker.sv
// checker: bus handshake and instruction timing of the adjust/decrement unit
`timescale 1ns/100ps

module bds_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic busy,
  input wire logic skip_pending
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_req_answer: assert property (req && !(wb_we_i && busy) |=> wb_ack_o)
    else $error("idle request not answered next cycle");
  // a write during an instruction must wait, but is answered within six cycles
  chk_write_wait: assert property (req && wb_we_i && busy |-> ##[1:6] wb_ack_o)
    else $error("write during execution never answered");
  chk_busy_wack: assert property (busy && wb_we_i && wb_cyc_i |-> !wb_ack_o)
    else $error("write acked while busy");
  chk_busy_len: assert property ($rose(busy) |-> busy[*4] ##1 !busy)
    else $error("instruction not four phases long");
  chk_busy_cause: assert property (
    $rose(busy) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == bds_pkg::OFS_INSTR))
    else $error("execution started without instruction write");
  chk_skip_stable: assert property (!busy && !$past(busy) |-> $stable(skip_pending))
    else $error("skip flag moved while idle");
  chk_skip_source: assert property ($rose(skip_pending) |-> $past(busy))
    else $error("skip flag set without an instruction");
endmodule

bind bds_unit bds_checker bds_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .busy(busy), .skip_pending(skip_pending));

// >>> tb/bds_unit_test.sv
// testbench: register-level checks of the adjust/decrement/skip unit
`timescale 1ns/100ps

module bds_unit_test;
  typedef struct packed {
    logic [15:0] op;
    logic [7:0] acc_in;
    logic [4:0] st_in;
    logic [11:0] ma;
    logic [7:0] mv;
    logic [7:0] acc_x;
    logic [7:0] mem_x;
    logic [4:0] st_x;
    logic sk;
    logic tw;
  } bds_case_t;

  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic ack;
  logic busy;
  logic skip_pending;
  logic [31:0] q;
  int err_count = 0;
  int comparisons = 0;
  // op, acc in, status in, file addr, file value, acc/file/status expected, skip, two-word
  bds_case_t cases [0:11] = '{
    '{16'h0007, 8'hA5, 5'h00, 12'h000, 8'h00, 8'h05, 8'h00, 5'h01, 1'h0, 1'h0},
    '{16'h0007, 8'hCE, 5'h00, 12'h000, 8'h00, 8'h34, 8'h00, 5'h03, 1'h0, 1'h0},
    '{16'h0007, 8'h12, 5'h1E, 12'h000, 8'h00, 8'h18, 8'h00, 5'h1C, 1'h0, 1'h0},
    '{16'h0007, 8'h99, 5'h01, 12'h000, 8'h00, 8'hF9, 8'h00, 5'h01, 1'h0, 1'h0},
    '{16'h0007, 8'h9A, 5'h00, 12'h000, 8'h00, 8'h00, 8'h00, 5'h03, 1'h0, 1'h0},
    '{16'h0620, 8'h55, 5'h00, 12'h020, 8'h80, 8'h55, 8'h7F, 5'h09, 1'h0, 1'h0},
    '{16'h0520, 8'h55, 5'h00, 12'h320, 8'h01, 8'h00, 8'h01, 5'h07, 1'h0, 1'h0},
    '{16'h0690, 8'h55, 5'h1F, 12'hF90, 8'h00, 8'h55, 8'hFF, 5'h10, 1'h0, 1'h0},
    '{16'h2F20, 8'h55, 5'h15, 12'h320, 8'h01, 8'h55, 8'h00, 5'h15, 1'h1, 1'h0},
    '{16'h2C20, 8'h55, 5'h15, 12'h020, 8'h03, 8'h02, 8'h03, 5'h15, 1'h0, 1'h0},
    '{16'h4C20, 8'h55, 5'h0A, 12'h020, 8'h05, 8'h04, 8'h05, 5'h0A, 1'h1, 1'h1},
    '{16'h4F20, 8'h55, 5'h0A, 12'h320, 8'h01, 8'h55, 8'h00, 5'h0A, 1'h0, 1'h0}};

  always #5 clk = ~clk;

  bds_unit bds_unit_inst (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .busy(busy), .skip_pending(skip_pending));

  task automatic test_done();
    if (err_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(inout int n);
    n++;
    if (n > 50)
    begin
      err_count++;
      test_done();
    end
    @(negedge clk);
  endtask

  // classic cycle: request held until ack is seen, released at the next rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    @(negedge clk);
    while (ack !== 1'h1)
      tick(n);
    // read data is taken at the rising edge that samples ack high
    @(posedge clk);
    q = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 4'hF);
  endtask

  task automatic rd(input logic [7:0] a);
    xfer(1'h0, a, 32'h0000_0000, 4'hF);
  endtask

  task automatic exec(input logic [15:0] op);
    int n;
    n = 0;
    wr(bds_pkg::OFS_INSTR, {16'h0000, op});
    @(negedge clk);
    while (busy !== 1'h0)
      tick(n);
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    for (int k = 1; k < 4; k++)
    begin
      rd(8'(k * 4));
      check("reset value", q, 32'h0000_0000);
    end
    wr(bds_pkg::OFS_BANK, 32'h0000_0003);
    foreach (cases[i])
    begin
      wr(bds_pkg::OFS_ACC, {24'h00_0000, cases[i].acc_in});
      wr(bds_pkg::OFS_STATUS, {27'h000_0000, cases[i].st_in});
      wr(bds_pkg::OFS_MADDR, {20'h0_0000, cases[i].ma});
      wr(bds_pkg::OFS_MDATA, {24'h00_0000, cases[i].mv});
      exec(cases[i].op);
      rd(bds_pkg::OFS_ACC);
      check("acc", q, {24'h00_0000, cases[i].acc_x});
      rd(bds_pkg::OFS_STATUS);
      check("status", q, {27'h000_0000, cases[i].st_x});
      rd(bds_pkg::OFS_MDATA);
      check("file byte", q, {24'h00_0000, cases[i].mem_x});
      check("skip", skip_pending, cases[i].sk);
      if (cases[i].sk)
      begin
        if (cases[i].tw)
        begin
          exec(16'hEF00);
          check("skip second word", skip_pending, 1'h1);
        end
        // the repeated word must be discarded, leaving results untouched
        exec(cases[i].op);
        rd(bds_pkg::OFS_ACC);
        check("acc after squash", q, {24'h00_0000, cases[i].acc_x});
        rd(bds_pkg::OFS_MDATA);
        check("file after squash", q, {24'h00_0000, cases[i].mem_x});
        check("skip cleared", skip_pending, 1'h0);
      end
    end
    exec(16'h0000);
    wr(bds_pkg::OFS_INSTR, 32'h0000_0000);
    wr(bds_pkg::OFS_ACC, 32'h0000_0033);
    xfer(1'h1, bds_pkg::OFS_ACC, 32'h0000_00AA, 4'hE);
    wr(8'h1C, 32'h0000_0011);
    rd(bds_pkg::OFS_ACC);
    check("acc after busy write", q, 32'h0000_0033);
    rd(8'h1C);
    check("unmapped read", q, 32'h0000_0000);
    rd(bds_pkg::OFS_INFO);
    check("executed words", q, 32'h0011_0000);
    test_done();
  end
endmodule
